//--- logic/msgbuf_pkg.sv
// Purpose: Shared constants for the message buffer control block
// Assumes: 32 buffers, 8 memory words per buffer, 16-bit words
// Notes:   Control byte layout is shared by both buffers of a pair
// Function
// - Direction bit per buffer, one means transmit, zero means receive.
// - Read-only aborted flag set on abort, clear after successful send.
// - Read-only arbitration-lost flag set when sending loses arbitration.
// - Read-only send error flag set on bus error while sending.
// - Setting send request clears aborted, arbitration-lost and error flags.
// - Writing one requests sending; hardware clears it after success.
// - Writing zero while request is set asks to abort message.
// - Auto remote reply sets send request on matching remote frame.
// - Two-bit priority, 00 lowest up to 11 highest.
// - Each 16-bit control register serves even (low) and odd (high) buffer.
// - 32 buffers whose message words live in DMA RAM.
// - First word holds standard identifier at 12..2, top three bits zero.
// - First word bit 1 is substitute remote request bit.
// - First word bit 0 selects extended identifier.
// - Second word holds extended identifier 17..6 at 11..0, top zero.
// - Third word holds extended identifier 5..0 at 15..10, RTR at 9.
// - Third word low four bits hold length code, 7..5 read zero.
// - Data bytes packed two per word, high byte holds next index.
// - Receive store writes matching filter number to status bits 12..8.
package msgbuf_pkg;
   localparam int NUM_BUF     = 32;
   localparam int BUF_W       = 5;
   localparam int WORDS_PER   = 8;
   localparam int WORD_W      = 3;
   localparam int MEM_AW      = BUF_W + WORD_W;
   localparam int PAIR_W      = 4;
   // Control byte field positions
   localparam int CTL_DIR     = 7;
   localparam int CTL_ABT     = 6;
   localparam int CTL_LARB    = 5;
   localparam int CTL_ERR     = 4;
   localparam int CTL_REQ     = 3;
   localparam int CTL_RTREN   = 2;
   localparam int CTL_PRI_HI  = 1;
   localparam int CTL_PRI_LO  = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;
   // Word index within a buffer
   localparam logic [WORD_W-1:0] WORD_SID  = 3'h0;
   localparam logic [WORD_W-1:0] WORD_EID  = 3'h1;
   localparam logic [WORD_W-1:0] WORD_DLC  = 3'h2;
   localparam logic [WORD_W-1:0] WORD_D01  = 3'h3;
   localparam logic [WORD_W-1:0] WORD_D23  = 3'h4;
   localparam logic [WORD_W-1:0] WORD_D45  = 3'h5;
   localparam logic [WORD_W-1:0] WORD_D67  = 3'h6;
   localparam logic [WORD_W-1:0] WORD_STAT = 3'h7;
   // Implemented bits per word
   localparam logic [15:0] MASK_SID  = 16'h1fff;
   localparam logic [15:0] MASK_EID  = 16'h0fff;
   localparam logic [15:0] MASK_DLC  = 16'hff1f;
   localparam logic [15:0] MASK_DATA = 16'hffff;
   localparam logic [15:0] MASK_STAT = 16'h1f00;
   localparam int STAT_FIL_LO = 8;
   localparam int FIL_W       = 5;

   // Keeps unimplemented bits of a buffer word at zero
   function automatic logic [15:0] word_mask(input logic [WORD_W-1:0] idx);
      case (idx)
         WORD_SID:  word_mask = MASK_SID;
         WORD_EID:  word_mask = MASK_EID;
         WORD_DLC:  word_mask = MASK_DLC;
         WORD_STAT: word_mask = MASK_STAT;
         default:   word_mask = MASK_DATA;
      endcase
   endfunction

   function automatic logic [MEM_AW-1:0] mem_addr(input logic [BUF_W-1:0] buf_n,
                                                 input logic [WORD_W-1:0] idx);
      mem_addr = {buf_n, idx};
   endfunction
endpackage

//--- logic/msgbuf_ram.sv
// Purpose: Two-port message RAM holding all buffer words
// Assumes: Port b wins when both ports write one address
// Notes:   Read data registered on both ports
module msgbuf_ram #(
   parameter int AW = 8,
   parameter int DW = 16
) (
   // Clock and reset
   input  wire logic          clk_sys_in,
   input  wire logic          arst_n_in,
   // Port a
   input  wire logic          a_wr_in,
   input  wire logic [AW-1:0] a_addr_in,
   input  wire logic [DW-1:0] a_wdata_in,
   output logic      [DW-1:0] a_rdata_out,
   // Port b
   input  wire logic          b_wr_in,
   input  wire logic [AW-1:0] b_addr_in,
   input  wire logic [DW-1:0] b_wdata_in,
   output logic      [DW-1:0] b_rdata_out
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk_sys_in) begin
      if (a_wr_in && !(b_wr_in && b_addr_in == a_addr_in)) begin
         mem[a_addr_in] <= a_wdata_in;
      end
      if (b_wr_in) begin
         mem[b_addr_in] <= b_wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         a_rdata_out <= '0;
         b_rdata_out <= '0;
      end else begin
         a_rdata_out <= mem[a_addr_in];
         b_rdata_out <= mem[b_addr_in];
      end
   end
endmodule

//--- logic/msgbuf_pick.sv
// Purpose: Chooses the next transmit buffer among eligible ones
// Assumes: Eligibility and priorities come from registers
// Notes:   Purely combinational
module msgbuf_pick #(
   parameter int N  = 32,
   parameter int BW = 5
) (
   // Candidates
   input  wire logic [N-1:0]   elig_in,
   input  wire logic [2*N-1:0] pri_in,
   // Choice
   output logic                valid_out,
   output logic [BW-1:0]       buf_out
);
   always_comb begin
      logic [1:0] best;
      best      = 2'h0;
      valid_out = 1'b0;
      buf_out   = '0;
      for (int i = 0; i < N; i++) begin
         // Ascending scan with >= lets higher number win ties
         if (elig_in[i] && (!valid_out || pri_in[2*i +: 2] >= best)) begin
            valid_out = 1'b1;
            best      = pri_in[2*i +: 2];
            buf_out   = BW'(i);
         end
      end
   end
endmodule

//--- logic/msgbuf_ctrl.sv
// Purpose: Control registers and message RAM for 32 CAN message buffers
// Assumes: Engine events are one-cycle pulses for the buffer in flight
// Notes:   Control pairs reached through the peripheral register port
module msgbuf_ctrl
   import msgbuf_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys_in,
   input  wire logic              arst_n_in,
   // Peripheral register port
   input  wire logic              sfr_wr_in,
   input  wire logic              sfr_rd_in,
   input  wire logic [PAIR_W-1:0] sfr_sel_in,
   input  wire logic [1:0]        sfr_be_in,
   input  wire logic [15:0]       sfr_wdata_in,
   output logic      [15:0]       sfr_rdata_out,
   // DMA port into buffer RAM
   input  wire logic              dma_wr_in,
   input  wire logic [MEM_AW-1:0] dma_addr_in,
   input  wire logic [15:0]       dma_wdata_in,
   output logic      [15:0]       dma_rdata_out,
   // Protocol engine RAM port
   input  wire logic              eng_wr_in,
   input  wire logic [MEM_AW-1:0] eng_addr_in,
   input  wire logic [15:0]       eng_wdata_in,
   output logic      [15:0]       eng_rdata_out,
   // Protocol engine transmit handshake
   output logic                   tx_start_out,
   output logic      [BUF_W-1:0]  tx_buf_out,
   output logic                   tx_abort_out,
   input  wire logic              tx_ok_in,
   input  wire logic              tx_aborted_in,
   input  wire logic              tx_lost_in,
   input  wire logic              tx_err_in,
   // Protocol engine receive events
   input  wire logic              rx_done_in,
   input  wire logic [BUF_W-1:0]  rx_buf_in,
   input  wire logic [FIL_W-1:0]  rx_filter_in,
   input  wire logic              rx_remote_in,
   // Buffer directions
   output logic      [NUM_BUF-1:0] buffer_direction_select_out
);
   // Per-buffer control state
   logic [NUM_BUF-1:0]   dir_q;
   logic [NUM_BUF-1:0]   req_q;
   logic [NUM_BUF-1:0]   rtren_q;
   logic [2*NUM_BUF-1:0] pri_q;
   logic [NUM_BUF-1:0]   abt_q;
   logic [NUM_BUF-1:0]   larb_q;
   logic [NUM_BUF-1:0]   err_q;
   logic [NUM_BUF-1:0]   abort_pend_q;
   // Transmit in flight
   logic                 active_q;
   logic [BUF_W-1:0]     act_buf_q;
   logic                 tx_start_q;
   logic                 tx_abort_q;
   // Arbitration
   logic [NUM_BUF-1:0]   elig;
   logic                 pick_valid;
   logic [BUF_W-1:0]     pick_buf;
   // RAM port b mux
   logic                 b_wr;
   logic [MEM_AW-1:0]    b_addr;
   logic [15:0]          b_wdata;
   logic                 tx_end;

   assign tx_end = tx_ok_in || tx_aborted_in || tx_lost_in || tx_err_in;

   // Control byte of one buffer as read back
   function automatic logic [7:0] ctl_byte(input int i);
      logic [7:0] b;
      b              = CTL_RESET;
      b[CTL_DIR]     = dir_q[i];
      b[CTL_ABT]     = abt_q[i];
      b[CTL_LARB]    = larb_q[i];
      b[CTL_ERR]     = err_q[i];
      b[CTL_REQ]     = req_q[i];
      b[CTL_RTREN]   = rtren_q[i];
      b[CTL_PRI_HI:CTL_PRI_LO] = pri_q[2*i +: 2];
      return b;
   endfunction

   // Per-buffer control registers and flags
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dir_q        <= '0;
         req_q        <= '0;
         rtren_q      <= '0;
         pri_q        <= '0;
         abt_q        <= '0;
         larb_q       <= '0;
         err_q        <= '0;
         abort_pend_q <= '0;
      end else begin
         for (int i = 0; i < NUM_BUF; i++) begin
            logic       hit;
            logic       is_act;
            logic [7:0] wb;
            hit    = sfr_wr_in && (sfr_sel_in == PAIR_W'(i >> 1))
                     && sfr_be_in[i % 2];
            is_act = active_q && (act_buf_q == BUF_W'(i));
            wb     = (i % 2 == 1) ? sfr_wdata_in[15:8] : sfr_wdata_in[7:0];
            // Outcome of the attempt in flight
            if (is_act) begin
               if (tx_ok_in) begin
                  req_q[i]        <= 1'b0;
                  abt_q[i]        <= 1'b0;
                  abort_pend_q[i] <= 1'b0;
               end
               if (tx_aborted_in) begin
                  req_q[i]        <= 1'b0;
                  abt_q[i]        <= 1'b1;
                  abort_pend_q[i] <= 1'b0;
               end
               if (tx_lost_in) begin
                  larb_q[i] <= 1'b1;
               end
               if (tx_err_in) begin
                  err_q[i] <= 1'b1;
               end
               // Failed attempt with abort pending ends the request
               if ((tx_lost_in || tx_err_in) && abort_pend_q[i]) begin
                  req_q[i]        <= 1'b0;
                  abt_q[i]        <= 1'b1;
                  abort_pend_q[i] <= 1'b0;
               end
            end
            // Software write of the control byte
            if (hit) begin
               dir_q[i]          <= wb[CTL_DIR];
               rtren_q[i]        <= wb[CTL_RTREN];
               pri_q[2*i +: 2]   <= wb[CTL_PRI_HI:CTL_PRI_LO];
               if (wb[CTL_REQ]) begin
                  req_q[i]        <= 1'b1;
                  abt_q[i]        <= 1'b0;
                  larb_q[i]       <= 1'b0;
                  err_q[i]        <= 1'b0;
                  abort_pend_q[i] <= 1'b0;
               end else if (req_q[i]) begin
                  if (is_act && !tx_end) begin
                     abort_pend_q[i] <= 1'b1;
                  end else begin
                     req_q[i] <= 1'b0;
                     abt_q[i] <= 1'b1;
                  end
               end
            end
            // Remote frame matched this buffer
            if (rx_remote_in && rx_buf_in == BUF_W'(i) && rtren_q[i] && dir_q[i]) begin
               req_q[i]        <= 1'b1;
               abt_q[i]        <= 1'b0;
               larb_q[i]       <= 1'b0;
               err_q[i]        <= 1'b0;
               abort_pend_q[i] <= 1'b0;
            end
         end
      end
   end

   // Eligible transmit buffers
   always_comb begin
      for (int i = 0; i < NUM_BUF; i++) begin
         elig[i] = dir_q[i] && req_q[i] && !abort_pend_q[i];
      end
   end

   msgbuf_pick #(
      .N  (NUM_BUF),
      .BW (BUF_W)
   ) u_pick (
      .elig_in   (elig),
      .pri_in    (pri_q),
      .valid_out (pick_valid),
      .buf_out   (pick_buf)
   );

   // Transmit start and in-flight tracking
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         active_q   <= 1'b0;
         act_buf_q  <= '0;
         tx_start_q <= 1'b0;
      end else begin
         tx_start_q <= 1'b0;
         if (active_q) begin
            if (tx_end) begin
               active_q <= 1'b0;
            end
         end else if (pick_valid) begin
            active_q   <= 1'b1;
            act_buf_q  <= pick_buf;
            tx_start_q <= 1'b1;
         end
      end
   end

   // Abort request toward the engine
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tx_abort_q <= 1'b0;
      end else begin
         tx_abort_q <= active_q && !tx_end && abort_pend_q[act_buf_q];
      end
   end

   // Control pair read
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sfr_rdata_out <= '0;
      end else if (sfr_rd_in) begin
         sfr_rdata_out <= {ctl_byte(2 * int'(sfr_sel_in) + 1),
                           ctl_byte(2 * int'(sfr_sel_in))};
      end
   end

   // Receive status store takes port b over the engine
   always_comb begin
      if (rx_done_in && !dir_q[rx_buf_in]) begin
         b_wr    = 1'b1;
         b_addr  = mem_addr(rx_buf_in, WORD_STAT);
         b_wdata = MASK_STAT & ({11'h000, rx_filter_in} << STAT_FIL_LO);
      end else begin
         b_wr    = eng_wr_in;
         b_addr  = eng_addr_in;
         b_wdata = eng_wdata_in & word_mask(eng_addr_in[WORD_W-1:0]);
      end
   end

   // Buffer words in shared RAM
   msgbuf_ram #(
      .AW (MEM_AW),
      .DW (16)
   ) u_ram (
      .clk_sys_in  (clk_sys_in),
      .arst_n_in   (arst_n_in),
      .a_wr_in     (dma_wr_in),
      .a_addr_in   (dma_addr_in),
      .a_wdata_in  (dma_wdata_in & word_mask(dma_addr_in[WORD_W-1:0])),
      .a_rdata_out (dma_rdata_out),
      .b_wr_in     (b_wr),
      .b_addr_in   (b_addr),
      .b_wdata_in  (b_wdata),
      .b_rdata_out (eng_rdata_out)
   );

   assign tx_start_out                = tx_start_q;
   assign tx_buf_out                  = act_buf_q;
   assign tx_abort_out                = tx_abort_q;
   assign buffer_direction_select_out = dir_q;
endmodule

//--- tb/msgbuf_ctrl_properties.sv
// Purpose: Port checks for the buffer control block
// Assumes: Engine end events are one-cycle pulses
// Notes:   Bound from the bench top
module msgbuf_ctrl_chk
   import msgbuf_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   // Register port
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [PAIR_W-1:0] sfr_sel_in,
   input wire logic [1:0] sfr_be_in,
   input wire logic [15:0] sfr_wdata_in,
   input wire logic [15:0] sfr_rdata_out,
   // Engine side
   input wire logic tx_start_out,
   input wire logic [BUF_W-1:0] tx_buf_out,
   input wire logic tx_abort_out,
   input wire logic tx_ok_in,
   input wire logic tx_aborted_in,
   input wire logic tx_lost_in,
   input wire logic tx_err_in,
   input wire logic [NUM_BUF-1:0] buffer_direction_select_out
);
   logic end_w;
   logic busy_q;
   assign end_w = tx_ok_in | tx_aborted_in | tx_lost_in | tx_err_in;
   // Attempt in flight
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         busy_q <= 1'b0;
      end else if (tx_start_out) begin
         busy_q <= 1'b1;
      end else if (end_w) begin
         busy_q <= 1'b0;
      end
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);
   a_start_one_pulse: assert property (tx_start_out |=> !tx_start_out)
      else $error("start pulse too long");
   a_no_overlap: assert property (busy_q |-> !tx_start_out)
      else $error("start while busy");
   a_gap_after_end: assert property (end_w |=> !tx_start_out)
      else $error("start right after end");
   a_buf_steady: assert property (busy_q |-> $stable(tx_buf_out))
      else $error("buffer changed in flight");
   a_abort_in_flight: assert property (tx_abort_out |-> busy_q)
      else $error("abort with nothing in flight");
   a_abort_drops: assert property (tx_abort_out && end_w |=> !tx_abort_out)
      else $error("abort held after end");
   a_start_dir_tx: assert property (
      tx_start_out |-> buffer_direction_select_out[tx_buf_out])
      else $error("start of receive buffer");
   a_dir_low_byte: assert property (sfr_wr_in && sfr_be_in[0] |=>
      buffer_direction_select_out[{$past(sfr_sel_in), 1'b0}] == $past(sfr_wdata_in[7]))
      else $error("even direction wrong");
   a_dir_high_byte: assert property (sfr_wr_in && sfr_be_in[1] |=>
      buffer_direction_select_out[{$past(sfr_sel_in), 1'b1}] == $past(sfr_wdata_in[15]))
      else $error("odd direction wrong");
   a_rdata_holds: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
      else $error("read data moved");
endmodule

//--- tb/can_engine_model.sv
// Purpose: Protocol engine stand-in ending each attempt except outcome 3 with no abort
// Assumes: One attempt at a time
// Notes:   Outcome and speed set by the bench
module can_engine_model (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   // From the block
   input wire logic start_in,
   input wire logic abort_in,
   // Bench control
   input wire logic slow_in,
   input wire logic [1:0] fail_in,
   // End pulses
   output logic ok_out,
   output logic aborted_out,
   output logic lost_out,
   output logic err_out
);
   logic [3:0] cnt_q;
   logic [1:0] mode_q;
   logic fin_w;
   // Outcome latched at start, so the bench may change it mid-attempt
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_q  <= 4'h0;
         mode_q <= 2'h0;
      end else if (start_in) begin
         cnt_q  <= slow_in ? 4'hc : 4'h3;
         mode_q <= fail_in;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
   assign fin_w = (cnt_q == 4'h1);
   assign aborted_out = fin_w & abort_in;
   assign ok_out = fin_w & !abort_in & (mode_q == 2'h0);
   assign lost_out = fin_w & !abort_in & (mode_q == 2'h1);
   assign err_out = fin_w & !abort_in & (mode_q == 2'h2);
endmodule

//--- tb/can_message_buffer_control_bench.sv
// Purpose: Self-checking bench for the buffer control block
// Assumes: Engine model answers each start
// Notes:   Random words from a fixed-seed shift register
module can_message_buffer_control_bench import msgbuf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, dwr = 0, rxd = 0, rxr = 0, slow = 0;
   logic [3:0] sel = 0, s;
   logic [1:0] be = 0, fail = 0, pl, ph;
   logic [15:0] wd = 0, dwd = 0, rdat, drd, erd, d;
   logic [7:0] dad = 0, ead = 0, a;
   logic [4:0] rxb = 0, rxf = 0, tbuf, f;
   logic st, ab, ok, abt, lost, err;
   logic [31:0] dir, seed;
   logic [15:0] oc [4] = '{16'h8300, 16'ha300, 16'h9300, 16'hc300};
   int bad_count, tests_run, cyc;
   msgbuf_ctrl dut (.clk_sys_in(clk), .arst_n_in(rst_n), .sfr_wr_in(wr), .sfr_rd_in(rd),
      .sfr_sel_in(sel), .sfr_be_in(be), .sfr_wdata_in(wd), .sfr_rdata_out(rdat),
      .dma_wr_in(dwr), .dma_addr_in(dad), .dma_wdata_in(dwd), .dma_rdata_out(drd),
      .eng_wr_in(1'b0), .eng_addr_in(ead), .eng_wdata_in(16'h0000), .eng_rdata_out(erd),
      .tx_start_out(st), .tx_buf_out(tbuf), .tx_abort_out(ab), .tx_ok_in(ok),
      .tx_aborted_in(abt), .tx_lost_in(lost), .tx_err_in(err), .rx_done_in(rxd),
      .rx_buf_in(rxb), .rx_filter_in(rxf), .rx_remote_in(rxr),
      .buffer_direction_select_out(dir));
   can_engine_model eng (.clk_sys_in(clk), .arst_n_in(rst_n), .start_in(st),
      .abort_in(ab), .slow_in(slow), .fail_in(fail), .ok_out(ok),
      .aborted_out(abt), .lost_out(lost), .err_out(err));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [15:0] wmask(input logic [2:0] w);
      case (w)
         3'h0: wmask = 16'h1fff;
         3'h1: wmask = 16'h0fff;
         3'h2: wmask = 16'hff1f;
         3'h7: wmask = 16'h1f00;
         default: wmask = 16'hffff;
      endcase
   endfunction
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic sw(input logic [3:0] p, input logic [1:0] b, input logic [15:0] v);
      @(posedge clk);
      wr <= 1'b1;
      sel <= p;
      be <= b;
      wd <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic sr(input logic [3:0] p, input logic [15:0] e, input string n);
      @(posedge clk);
      rd <= 1'b1;
      sel <= p;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(n, e, rdat);
   endtask
   task automatic dw(input logic [7:0] ad, input logic [15:0] v);
      @(posedge clk);
      dwr <= 1'b1;
      dad <= ad;
      dwd <= v;
      @(posedge clk);
      dwr <= 1'b0;
   endtask
   task automatic dr(input logic [7:0] ad, input logic [15:0] e);
      @(posedge clk);
      dad <= ad;
      ead <= ad;
      @(posedge clk);
      #1 chk("ram word", e, drd);
      chk("engine word", e, erd);
   endtask
   task automatic rx(input logic done, input logic [4:0] b, input logic [4:0] fl);
      @(posedge clk);
      rxd <= done;
      rxr <= !done;
      rxb <= b;
      rxf <= fl;
      @(posedge clk);
      rxd <= 1'b0;
      rxr <= 1'b0;
   endtask
   task automatic wstart(input logic [4:0] b);
      int i;
      i = 0;
      do begin
         @(posedge clk);
         #1 i++;
      end while (st !== 1'b1 && i < 40);
      chk("tx start", {11'h001, b}, {10'h000, st, tbuf});
   endtask
   task automatic wend;
      int i;
      i = 0;
      do begin
         @(posedge clk);
         #1 i++;
      end while ((ok | abt | lost | err) !== 1'b1 && i < 40);
      chk("tx end", 16'h0001, {15'h0000, ok | abt | lost | err});
   endtask
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      seed = 32'hb9e9dc3f;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 16; k++) sr(k[3:0], 16'h0000, "pair reset");
      $display("done reset values");
      for (int k = 0; k < 24; k++) begin
         seed = lfsr(seed);
         a = (k < 8) ? {5'h1f, k[2:0]} : seed[7:0];
         d = (k < 8) ? 16'hffff : seed[23:8];
         if (a[2:0] == 3'h2) d = d & 16'hfeef;
         dw(a, d);
         dr(a, d & wmask(a[2:0]));
      end
      $display("done ram layout");
      sw(4'h7, 2'h3, 16'h7f7f);
      sr(4'h7, 16'h0f0f, "read-only flags");
      sw(4'h7, 2'h2, 16'h0000);
      sr(4'h7, 16'h400f, "idle abort");
      sw(4'h7, 2'h2, 16'h0800);
      sr(4'h7, 16'h080f, "request clears");
      sw(4'h7, 2'h3, 16'h0000);
      sr(4'h7, 16'h4040, "both abort");
      $display("done control bits");
      for (int m = 0; m < 4; m++) begin
         fail <= (m == 3) ? 2'h0 : m[1:0];
         slow <= (m == 3);
         sw(4'h1, 2'h2, 16'h8b00);
         wstart(5'h03);
         if (m == 3) sw(4'h1, 2'h2, 16'h8300);
         wend();
         if (m == 1 || m == 2) begin
            fail <= 2'h0;
            wstart(5'h03);
            wend();
         end
         sr(4'h1, oc[m], "outcome flags");
      end
      slow <= 1'b0;
      $display("done outcomes");
      for (int k = 0; k < 6; k++) begin
         seed = lfsr(seed);
         pl = (k == 0) ? 2'h3 : seed[1:0];
         ph = (k == 0) ? 2'h3 : seed[3:2];
         s = seed[7:4];
         sw(s, 2'h3, {6'h22, ph, 6'h22, pl});
         wstart({s, ph >= pl});
         wend();
         wstart({s, ph < pl});
         wend();
         sr(s, {6'h20, ph, 6'h20, pl}, "pair sent");
      end
      $display("done priority");
      sw(4'h2, 2'h3, 16'h0084);
      rx(1'b0, 5'h04, 5'h00);
      wstart(5'h04);
      wend();
      sw(4'h2, 2'h1, 16'h0080);
      rx(1'b0, 5'h04, 5'h00);
      sr(4'h2, 16'h0080, "remote off");
      $display("done remote reply");
      seed = lfsr(seed);
      f = seed[4:0];
      sw(4'h4, 2'h3, 16'h0000);
      dw(8'h4f, 16'h0000);
      rx(1'b1, 5'h09, f);
      dr(8'h4f, {3'h0, f, 8'h00});
      sw(4'h5, 2'h1, 16'h0080);
      dw(8'h57, 16'h0300);
      rx(1'b1, 5'h0a, 5'h1f);
      dr(8'h57, 16'h0300);
      $display("done filter status");
      summarize();
   end
endmodule
bind msgbuf_ctrl msgbuf_ctrl_chk chk (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
   .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_sel_in(sfr_sel_in),
   .sfr_be_in(sfr_be_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
   .tx_start_out(tx_start_out), .tx_buf_out(tx_buf_out), .tx_abort_out(tx_abort_out),
   .tx_ok_in(tx_ok_in), .tx_aborted_in(tx_aborted_in), .tx_lost_in(tx_lost_in),
   .tx_err_in(tx_err_in), .buffer_direction_select_out(buffer_direction_select_out));
